// File: design/qiorw_map.svh
// Constants of the quad I/O read and wrap-burst command logic.
// Assumes inclusion by the package and the core; definitions only.
`ifndef QIORW_MAP_SVH
`define QIORW_MAP_SVH

// Opcodes handled by this block
`define QIORW_OP_QIO_READ   8'hEB
`define QIORW_OP_WORD_READ  8'hE7
`define QIORW_OP_SET_WRAP   8'h77

// Serial clock edges per command phase
`define QIORW_OP_EDGES_SPI  6'h08
`define QIORW_OP_EDGES_QPI  6'h02
`define QIORW_ADDR_EDGES    6'h06
`define QIORW_MODE_EDGES    6'h02
`define QIORW_WRAP_EDGES    6'h20

// Dummy clocks after the mode byte in single-opcode mode
`define QIORW_SPI_QIO_DUMMY  6'h04
`define QIORW_SPI_WORD_DUMMY 6'h02

// Mode byte field: opcode skip select bits and the entry code
`define QIORW_SKIP_SEL_HI   5
`define QIORW_SKIP_SEL_LO   4
`define QIORW_SKIP_ENTER    2'h2

// Wrap byte field positions
`define QIORW_WRAP_LEN_HI   6
`define QIORW_WRAP_LEN_LO   5
`define QIORW_WRAP_DIS_POS  4

// Reset values and the idle byte sent on underrun
`define QIORW_WRAP_DIS_RST  1'h1
`define QIORW_WRAP_LEN_RST  2'h0
`define QIORW_PARAM_RST     2'h0
`define QIORW_IDLE_BYTE     8'hFF

`endif

// File: design/qiorw_pkg.sv
// Types shared by the quad I/O read command logic and its FIFO.
// Assumes the constant map header sits beside it.
`include "qiorw_map.svh"

package qiorw_pkg;

    // Command sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_WRAPCFG,
        ST_IGNORE
    } qiorw_state_t;

    // Pin group of the serial link
    typedef struct packed {
        logic       cs_b;
        logic       sclk;
        logic [3:0] io;
    } qiorw_pins_t;

    // Wrap setting as kept between commands
    typedef struct packed {
        logic [1:0] len;
        logic       dis;
    } qiorw_wrap_t;

endpackage : qiorw_pkg

// File: design/qiorw_fifo.sv
// Byte FIFO between the array read port and the nibble shifter.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps

module qiorw_fifo import qiorw_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             flush_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    // Pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("qiorw_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             load;

    // Refusing writes during flush keeps stale bytes out
    assign wr_ready_out = !flush_in && (cnt_ff != (AW+1)'(DEPTH));
    assign push         = wr_valid_in && wr_ready_out;
    assign load         = (cnt_ff != '0) && (!rd_valid_out || rd_ready_in);

    // Storage, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wp_ff] <= wr_data_in;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else if (flush_in) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= wp_ff + AW'(push);
            rp_ff  <= rp_ff + AW'(load);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Registered head word
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= '0;
        end else if (flush_in) begin
            rd_valid_out <= 1'b0;
        end else if (load) begin
            rd_valid_out <= 1'b1;
            rd_data_out  <= mem_ff[rp_ff];
        end else if (rd_ready_in) begin
            rd_valid_out <= 1'b0;
        end
    end

endmodule : qiorw_fifo

// File: design/qiorw_core.sv
// Quad I/O read and wrap-burst command logic of a serial flash.
// Assumes the link pins are asynchronous and sampled by clk_in
// (well above four times the serial clock); array bytes arrive
// as a stream for mem_addr_out, and the quad permit, four-wire
// mode and reset-instruction inputs come from logic on clk_in.
//
// Behaviour
// - Quad read: quad address/data, four dummies.
// - Quad read needs the quad permit bit.
// - Mode byte follows address; low nibble ignored.
// - Mode bits 10: next frame skips opcode.
// - Other mode bits: next frame needs opcode.
// - Wrap within aligned section until select rises.
// - Four-wire dummies 2/4/6/8 from read parameter.
// - Read parameter defaults to two dummies.
// - Four-wire mode counts mode byte as dummies.
// - Opcode skipping also works in four-wire mode.
// - No wrap for quad read in four-wire.
// - Word read: even address, two dummies.
// - Word read needs the quad permit bit.
// - Word read supports opcode skipping too.
// - Wrap setting applies to both quad reads.
// - Wrap command: opcode, 24 dummies, wrap byte.
// - Disable bit and two length bits decoded.
// - Wrap setting persists until rewritten.
// - Wrap disabled at power-on and reset.
// - Wrap command honoured only in single-opcode mode.
// - Sample on rising, shift out on falling.
`timescale 1ns/10ps
`include "qiorw_map.svh"

module qiorw_core import qiorw_pkg::*; #(
    parameter int FIFO_WIDTH = 8,
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        cs_b_in,
    input  wire logic        sclk_in,
    input  wire logic [3:0]  io_in,
    output logic [3:0]       io_out,
    output logic [3:0]       io_oe_out,
    input  wire logic        quad_io_permit_bit_in,
    input  wire logic        four_wire_command_mode_in,
    input  wire logic        soft_reset_in,
    input  wire logic        read_param_load_in,
    input  wire logic [1:0]  read_param_in,
    output logic [23:0]      mem_addr_out,
    input  wire logic [7:0]  mem_data_in,
    input  wire logic        mem_data_valid_in,
    output logic             mem_data_ready_out,
    output logic             continuous_read_out,
    output logic [2:0]       wrap_setting_bits_out,
    output logic [1:0]       read_param_out
);

    // The shifter moves whole bytes
    if (FIFO_WIDTH != 8) begin : g_chk
        $error("qiorw_core: FIFO_WIDTH must be 8");
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Dummy edges that follow the two mode-byte edges
    function automatic logic [5:0] dummy_edges(
        input logic [7:0] cmd,
        input logic       fw,
        input logic [1:0] prm
    );
        if (fw) begin
            dummy_edges = {3'h0, prm, 1'b0};
        end else if (cmd == `QIORW_OP_WORD_READ) begin
            dummy_edges = `QIORW_SPI_WORD_DUMMY;
        end else begin
            dummy_edges = `QIORW_SPI_QIO_DUMMY;
        end
    endfunction : dummy_edges

    // Next fetch address, wrapping inside the aligned section
    function automatic logic [23:0] next_addr(
        input logic [23:0] addr,
        input logic        wrap_on,
        input logic [1:0]  len
    );
        logic [7:0]  mask;
        logic [23:0] inc;
        mask = 8'h07;
        inc  = addr + 24'h000001;
        case (len)
            2'h0:    mask = 8'h07;
            2'h1:    mask = 8'h0F;
            2'h2:    mask = 8'h1F;
            default: mask = 8'h3F;
        endcase
        if (wrap_on) begin
            next_addr = {addr[23:8], (addr[7:0] & ~mask) | (inc[7:0] & mask)};
        end else begin
            next_addr = inc;
        end
    endfunction : next_addr

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    qiorw_pins_t  pin_s1_ff;
    qiorw_pins_t  pin_s2_ff;
    logic         sclk_d_ff;
    logic         cs_d_ff;
    logic         sclk_rise;
    logic         sclk_fall;
    logic         cs_fall;
    logic         cs_high;

    // Two stages; only the second one is looked at
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_ff <= '{cs_b: 1'b1, sclk: 1'b0, io: 4'h0};
            pin_s2_ff <= '{cs_b: 1'b1, sclk: 1'b0, io: 4'h0};
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
        end else begin
            pin_s1_ff <= '{cs_b: cs_b_in, sclk: sclk_in, io: io_in};
            pin_s2_ff <= pin_s1_ff;
            sclk_d_ff <= pin_s2_ff.sclk;
            cs_d_ff   <= pin_s2_ff.cs_b;
        end
    end

    // IO is synchronised with the same delay as the clock
    assign sclk_rise = pin_s2_ff.sclk && !sclk_d_ff;
    assign sclk_fall = !pin_s2_ff.sclk && sclk_d_ff;
    assign cs_fall   = !pin_s2_ff.cs_b && cs_d_ff;
    assign cs_high   = pin_s2_ff.cs_b;

    ////////////////////////////////////////////////////////////////////
    // Command sequencer

    qiorw_state_t state_ff;
    logic [5:0]   cnt_ff;
    logic [31:0]  shift_ff;
    logic [7:0]   cmd_ff;
    logic [31:0]  shift1;
    logic [31:0]  shift4;
    logic [7:0]   new_op;
    logic         last_edge;
    logic         op_done;
    logic         addr_done;
    logic         mode_done;
    logic         wrap_done;
    logic         fw;
    logic         crm_ff;
    logic [1:0]   param_ff;
    qiorw_wrap_t  wrap_ff;

    assign fw        = four_wire_command_mode_in;
    assign shift1    = {shift_ff[30:0], pin_s2_ff.io[0]};
    assign shift4    = {shift_ff[27:0], pin_s2_ff.io};
    assign new_op    = fw ? shift4[7:0] : shift1[7:0];
    assign last_edge = sclk_rise && (cnt_ff == 6'h01);
    assign op_done   = last_edge && (state_ff == ST_OPCODE);
    assign addr_done = last_edge && (state_ff == ST_ADDR);
    assign mode_done = last_edge && (state_ff == ST_MODE);
    assign wrap_done = last_edge && (state_ff == ST_WRAPCFG);

    // Phase walk; chip select high aborts anything
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 6'h00;
            shift_ff <= 32'h0000_0000;
            cmd_ff   <= `QIORW_OP_QIO_READ;
        end else if (cs_high) begin
            state_ff <= ST_IDLE;
        end else if (cs_fall) begin
            shift_ff <= 32'h0000_0000;
            if (crm_ff) begin
                state_ff <= ST_ADDR;
                cnt_ff   <= `QIORW_ADDR_EDGES;
            end else begin
                state_ff <= ST_OPCODE;
                cnt_ff   <= fw ? `QIORW_OP_EDGES_QPI : `QIORW_OP_EDGES_SPI;
            end
        end else if (sclk_rise) begin
            cnt_ff <= cnt_ff - 6'h01;
            case (state_ff)
                ST_OPCODE: begin
                    shift_ff <= fw ? shift4 : shift1;
                    if (cnt_ff == 6'h01) begin
                        cmd_ff <= new_op;
                        if (new_op == `QIORW_OP_QIO_READ
                            && quad_io_permit_bit_in) begin
                            state_ff <= ST_ADDR;
                            cnt_ff   <= `QIORW_ADDR_EDGES;
                        end else if (new_op == `QIORW_OP_WORD_READ
                            && quad_io_permit_bit_in && !fw) begin
                            state_ff <= ST_ADDR;
                            cnt_ff   <= `QIORW_ADDR_EDGES;
                        end else if (new_op == `QIORW_OP_SET_WRAP
                            && !fw) begin
                            state_ff <= ST_WRAPCFG;
                            cnt_ff   <= `QIORW_WRAP_EDGES;
                        end else begin
                            state_ff <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    shift_ff <= shift4;
                    if (cnt_ff == 6'h01) begin
                        state_ff <= ST_MODE;
                        cnt_ff   <= `QIORW_MODE_EDGES;
                    end
                end
                ST_MODE: begin
                    shift_ff <= shift4;
                    if (cnt_ff == 6'h01) begin
                        cnt_ff <= dummy_edges(cmd_ff, fw, param_ff);
                        if (dummy_edges(cmd_ff, fw, param_ff) == 6'h00) begin
                            state_ff <= ST_DATA;
                        end else begin
                            state_ff <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (cnt_ff == 6'h01) begin
                        state_ff <= ST_DATA;
                    end
                end
                ST_WRAPCFG: begin
                    shift_ff <= shift1;
                    if (cnt_ff == 6'h01) begin
                        state_ff <= ST_IGNORE;
                    end
                end
                default: begin
                    cnt_ff <= cnt_ff;
                end
            endcase
        end
    end

    // Mode byte governs whether the next frame carries an opcode
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crm_ff <= 1'b0;
        end else if (soft_reset_in) begin
            crm_ff <= 1'b0;
        end else if (mode_done) begin
            crm_ff <= (shift4[`QIORW_SKIP_SEL_HI:`QIORW_SKIP_SEL_LO]
                       == `QIORW_SKIP_ENTER);
        end
    end

    // Wrap setting kept across commands
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wrap_ff <= '{len: `QIORW_WRAP_LEN_RST, dis: `QIORW_WRAP_DIS_RST};
        end else if (soft_reset_in) begin
            wrap_ff <= '{len: `QIORW_WRAP_LEN_RST, dis: `QIORW_WRAP_DIS_RST};
        end else if (wrap_done) begin
            wrap_ff.len <= shift1[`QIORW_WRAP_LEN_HI:`QIORW_WRAP_LEN_LO];
            wrap_ff.dis <= shift1[`QIORW_WRAP_DIS_POS];
        end
    end

    // Read parameter written by the parameter-setting logic
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            param_ff <= `QIORW_PARAM_RST;
        end else if (soft_reset_in) begin
            param_ff <= `QIORW_PARAM_RST;
        end else if (read_param_load_in) begin
            param_ff <= read_param_in;
        end
    end

    assign continuous_read_out   = crm_ff;
    assign wrap_setting_bits_out = {wrap_ff.len, wrap_ff.dis};
    assign read_param_out        = param_ff;

    ////////////////////////////////////////////////////////////////////
    // Array fetch and FIFO

    logic        fetch_en_ff;
    logic        wrap_on_ff;
    logic [23:0] mem_addr_ff;
    logic        fifo_flush;
    logic        fifo_wr_ready;
    logic        fifo_rd_valid;
    logic [7:0]  fifo_rd_data;
    logic        pop;
    logic        mem_take;

    assign fifo_flush         = cs_high || addr_done;
    assign mem_data_ready_out = fifo_wr_ready && fetch_en_ff;
    assign mem_take           = mem_data_valid_in && mem_data_ready_out;
    assign mem_addr_out       = mem_addr_ff;

    // Prefetch starts at the address; wrap is frozen per frame
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fetch_en_ff <= 1'b0;
            wrap_on_ff  <= 1'b0;
            mem_addr_ff <= 24'h000000;
        end else if (cs_high) begin
            fetch_en_ff <= 1'b0;
        end else if (addr_done) begin
            fetch_en_ff <= 1'b1;
            mem_addr_ff <= shift4[23:0];
            wrap_on_ff  <= !wrap_ff.dis && !fw;
        end else if (mem_take) begin
            mem_addr_ff <= next_addr(mem_addr_ff, wrap_on_ff, wrap_ff.len);
        end
    end

    qiorw_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .flush_in     (fifo_flush),
        .wr_valid_in  (mem_data_valid_in && fetch_en_ff),
        .wr_ready_out (fifo_wr_ready),
        .wr_data_in   (mem_data_in),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (pop),
        .rd_data_out  (fifo_rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Nibble output

    logic       half_ff;
    logic [3:0] low_ff;
    logic [7:0] cur_byte;

    // An underrun sends the idle byte rather than stalling the link
    assign cur_byte = fifo_rd_valid ? fifo_rd_data : `QIORW_IDLE_BYTE;
    assign pop      = sclk_fall && (state_ff == ST_DATA) && !half_ff
                      && fifo_rd_valid;

    // Drive on falling edges, high nibble first
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_out    <= 4'h0;
            io_oe_out <= 4'h0;
            half_ff   <= 1'b0;
            low_ff    <= 4'h0;
        end else if (state_ff != ST_DATA) begin
            io_oe_out <= 4'h0;
            half_ff   <= 1'b0;
        end else if (sclk_fall) begin
            io_oe_out <= 4'hF;
            half_ff   <= !half_ff;
            if (!half_ff) begin
                io_out <= cur_byte[7:4];
                low_ff <= cur_byte[3:0];
            end else begin
                io_out <= low_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    permit_gate_a: assert property (
        op_done && !quad_io_permit_bit_in
        |=> state_ff inside {ST_IGNORE, ST_WRAPCFG, ST_IDLE})
        else $error("quad read accepted without permit");

    skip_enter_a: assert property (
        mode_done && shift4[5:4] == 2'h2 && !soft_reset_in |=> crm_ff)
        else $error("opcode skip not entered");

    skip_leave_a: assert property (
        mode_done && shift4[5:4] != 2'h2 |=> !crm_ff)
        else $error("opcode skip not left");

    skip_frame_a: assert property (
        cs_fall && crm_ff |=> state_ff == ST_ADDR && cnt_ff == 6'h06)
        else $error("skip frame did not start with address");

    quad_dummy_a: assert property (
        mode_done && !fw && cmd_ff == 8'hEB
        |=> state_ff == ST_DUMMY && cnt_ff == 6'h04)
        else $error("quad read dummy count wrong");

    word_dummy_a: assert property (
        mode_done && !fw && cmd_ff == 8'hE7
        |=> state_ff == ST_DUMMY && cnt_ff == 6'h02)
        else $error("word read dummy count wrong");

    qpi_default_a: assert property (
        mode_done && fw && param_ff == 2'h0 |=> state_ff == ST_DATA)
        else $error("default four-wire data not after mode");

    wrap_reset_a: assert property (
        soft_reset_in |=> wrap_ff.dis ##0 param_ff == 2'h0)
        else $error("reset did not restore defaults");

    wrap_qpi_a: assert property (
        addr_done && fw |=> !wrap_on_ff)
        else $error("wrap enabled in four-wire mode");

    oe_data_a: assert property (
        io_oe_out != 4'h0 |-> $past(state_ff) == ST_DATA)
        else $error("IO driven outside data phase");

endmodule : qiorw_core

// File: tb/qiorw_host.sv
// Host controller model driving chip select, serial clock and IO.
// Assumes the bench clock at 5 ns; one serial clock takes 125 ns.
`timescale 1ns/10ps

module qiorw_host (
    input  wire logic       clk_in,
    input  wire logic [3:0] io_in,
    output logic            cs_b_out,
    output logic            sclk_out,
    output logic [3:0]      io_out,
    output logic            io_oe_out
);
    logic [3:0] last_nib;

    // Clock parked low and select high outside frames
    initial begin
        cs_b_out  = 1'b1;
        sclk_out  = 1'b0;
        io_out    = 4'hF;
        io_oe_out = 1'b0;
        last_nib  = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // One serial clock; lines sampled just before the rise
    task automatic tick(input logic [3:0] v, input logic drv);
        io_out    = v;
        io_oe_out = drv;
        repeat (12) @(negedge clk_in);
        last_nib  = io_in;
        sclk_out  = 1'b1;
        repeat (4) @(negedge clk_in);
        // Let go early so no later fall can see a fight
        io_oe_out = 1'b0;
        repeat (9) @(negedge clk_in);
        sclk_out  = 1'b0;
    endtask : tick

    // Byte on IO0, most significant bit first
    task automatic send_s(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) tick({3'h7, b[i]}, 1'b1);
    endtask : send_s

    // Nibbles on all four lines, high nibble first
    task automatic send_q(input logic [23:0] v, input int nb);
        for (int i = nb - 1; i >= 0; i--) tick(v[i*4+:4], 1'b1);
    endtask : send_q

    // Raised select held well over three clocks
    task automatic stop();
        cs_b_out  = 1'b1;
        io_oe_out = 1'b0;
        repeat (10) @(negedge clk_in);
    endtask : stop
endmodule : qiorw_host

// File: tb/test_quad_io_read_wrap_logic.sv
// Self-checking bench for the quad I/O read and wrap-burst logic.
// Assumes the host model; array byte is its address xor 3Ch.
`timescale 1ns/10ps

module test_quad_io_read_wrap_logic;
    logic        clk_in, rst_b = 1'b0, permit = 1'b1, fw = 1'b0;
    logic        srst = 1'b0, pld = 1'b0, valid = 1'b0, h_oe, h_cs;
    logic        h_sclk, cont, ready;
    logic [1:0]  prm = 2'h0, rprm;
    logic [3:0]  dut_io, dut_oe, h_io, io_w;
    logic [23:0] maddr;
    logic [2:0]  wrap;
    int          cyc = 0, oe_cnt = 0, oe_base = 0, miscompares = 0;
    int          n_compared = 0;

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Released lines show the inverse, so a stale value cannot pass
    assign io_w = dut_oe[0] ? dut_io : (h_oe ? h_io : ~h_io);

    // Cycle ceiling, drive count and array stalls
    always @(posedge clk_in) begin
        cyc    <= cyc + 1;
        oe_cnt <= oe_cnt + int'(dut_oe != 4'h0);
        if (cyc == 40000) begin
            miscompares++;
            print_verdict();
        end
    end
    always @(negedge clk_in) valid <= (cyc % 7) != 3;

    qiorw_core DUT (
        .clk_in                    (clk_in),
        .rst_b_in                  (rst_b),
        .cs_b_in                   (h_cs),
        .sclk_in                   (h_sclk),
        .io_in                     (io_w),
        .io_out                    (dut_io),
        .io_oe_out                 (dut_oe),
        .quad_io_permit_bit_in     (permit),
        .four_wire_command_mode_in (fw),
        .soft_reset_in             (srst),
        .read_param_load_in        (pld),
        .read_param_in             (prm),
        .mem_addr_out              (maddr),
        .mem_data_in               (maddr[7:0] ^ 8'h3C),
        .mem_data_valid_in         (valid),
        .mem_data_ready_out        (ready),
        .continuous_read_out       (cont),
        .wrap_setting_bits_out     (wrap),
        .read_param_out            (rprm)
    );
    qiorw_host H (
        .clk_in    (clk_in),
        .io_in     (io_w),
        .cs_b_out  (h_cs),
        .sclk_out  (h_sclk),
        .io_out    (h_io),
        .io_oe_out (h_oe)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] ex, got);
        n_compared++;
        if (got !== ex) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
        @(negedge clk_in);
    endtask : pulse

    // Full read frame; expected bytes follow the wrap section
    task automatic qread(input logic [7:0] op, input bit skip, four_wire_command_mode,
                         input logic [23:0] a, input logic [7:0] m,
                         input int dum, n, wl);
        logic [7:0]  b;
        logic [23:0] e;
        H.cs_b_out = 1'b0;
        if (!skip && four_wire_command_mode) H.send_q({16'h0, op}, 2);
        if (!skip && !four_wire_command_mode) H.send_s(op);
        H.send_q(a, 6);
        H.send_q({16'h0, m}, 2);
        repeat (dum) H.tick(4'h0, 1'b0);
        for (int i = 0; i < n; i++) begin
            H.tick(4'h0, 1'b0);
            b[7:4] = H.last_nib;
            H.tick(4'h0, 1'b0);
            b[3:0] = H.last_nib;
            e = a + 24'(i);
            if (wl != 0) e = (a & ~24'(wl - 1)) | (e & 24'(wl - 1));
            chk("data", {16'h0, e[7:0] ^ 8'h3C}, {16'h0, b});
        end
        H.stop();
        chk("ready", 24'h0, {23'h0, ready});
    endtask : qread

    task automatic wrapcfg(input logic [7:0] w);
        H.cs_b_out = 1'b0;
        if (fw) H.send_q(24'h77, 2);
        else H.send_s(8'h77);
        repeat (3) H.send_s(8'h00);
        H.send_s(w);
        H.stop();
    endtask : wrapcfg

    task automatic print_verdict();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_in);
        rst_b = 1'b1;
        @(negedge clk_in);
        chk("wrap", 24'h1, {21'h0, wrap});
        chk("param", 24'h0, {22'h0, rprm});
        qread(8'hEB, 0, 0, 24'h0000FE, 8'h2A, 4, 4, 0);
        chk("skip", 24'h1, {23'h0, cont});
        qread(8'hEB, 1, 0, 24'h000100, 8'hFF, 4, 2, 0);
        chk("skip", 24'h0, {23'h0, cont});
        permit = 1'b0;
        for (int i = 0; i < 2; i++) begin
            oe_base = oe_cnt;
            H.cs_b_out = 1'b0;
            H.send_s(i ? 8'hE7 : 8'hEB);
            H.send_q(24'h0, 6);
            H.send_q(24'h0, 6);
            H.stop();
            chk("drive", 24'h0, 24'(oe_cnt - oe_base));
        end
        permit = 1'b1;
        for (int l = 0; l < 4; l++) begin
            wrapcfg({1'b1, 2'(l), 1'b0, 4'hF});
            chk("wrap", {21'h0, 2'(l), 1'b0}, {21'h0, wrap});
            qread(8'hE7, 0, 0, 24'h000400 + 24'((8 << l) - 2), 8'h00,
                  2, 3, 8 << l);
        end
        qread(8'hEB, 0, 0, 24'h00057E, 8'h00, 4, 3, 64);
        wrapcfg(8'h00);
        fw = 1'b1;
        wrapcfg(8'h10);
        chk("wrap", 24'h0, {21'h0, wrap});
        // Word read is refused in four-wire mode
        oe_base = oe_cnt;
        H.cs_b_out = 1'b0;
        H.send_q(24'hE7, 2);
        H.send_q(24'h0, 6);
        H.send_q(24'h0, 6);
        H.stop();
        chk("drive", 24'h0, 24'(oe_cnt - oe_base));
        prm = 2'h1;
        pulse(pld);
        chk("param", 24'h1, {22'h0, rprm});
        qread(8'hEB, 0, 1, 24'h000006, 8'h20, 2, 3, 0);
        qread(8'hEB, 1, 1, 24'h000010, 8'hFF, 2, 1, 0);
        chk("skip", 24'h0, {23'h0, cont});
        pulse(srst);
        chk("wrap", 24'h1, {21'h0, wrap});
        chk("param", 24'h0, {22'h0, rprm});
        qread(8'hEB, 0, 1, 24'h000020, 8'h00, 0, 2, 0);
        print_verdict();
    end
endmodule : test_quad_io_read_wrap_logic
